// ---- hw/urx_defines.svh ----
// Constants for the receive-path status register bank
// Operation
// (RULE_01) Always-on bit sends a status packet every interval; else only after enabled event.
// (RULE_02) Nine event enables each gate their own source; disabled events never send.
// (RULE_03) Eleven pin event enables in bits 10:0 gate pin events.
// (RULE_04) Short bulk-in packet waits programmed delay, 16.667 ns per count, reset 800h.
// (RULE_05) Read level grows by packet DWORD count once whole packet written.
// (RULE_06) Read level drops by one per DWORD read out.
// (RULE_07) Read-side rewind adds back DWORDs already read of that packet.
// (RULE_08) USB error during send rewinds read data and retransmits whole packet.
// (RULE_09) Write level grows by one per DWORD written.
// (RULE_10) Complete packet read out lowers write level by its DWORD count.
// (RULE_11) Write-side rewind lowers write level by DWORDs written of current packet.
// (RULE_12) Frame check error rewinds everything of that frame already written.
// (RULE_13) Read pointer shown as 13-bit read-only DWORD address, reset zero.
// (RULE_14) Write pointer shown as 13-bit read-only DWORD address, reset zero.
// (RULE_15) Enables and always-on bit reset zero, read/write; reserved bits read zero.
// (RULE_16) Read and write pointers wrap to zero after last FIFO location.
`ifndef URX_DEFINES_SVH
`define URX_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define URX_OFS_EP_CONTROL 8'h68
`define URX_OFS_BULK_DLY 8'h6C
`define URX_OFS_LVL_DBG 8'h70
`define URX_OFS_PTR_DBG 8'h74
`define URX_OFS_IRQ_STAT 8'h80
`define URX_OFS_IRQ_MASK 8'h84

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define URX_CTL_ALWAYS_ON 31
`define URX_CTL_WR_MASK 32'h800F_FFFF
`define URX_CTL_RESET 32'h0000_0000
`define URX_DLY_RESET 16'h0800
`define URX_PTR_LAST 13'h1FFF
`define URX_IRQ_BITS 4
`define URX_IRQ_STATUS_SENT 0
`define URX_IRQ_SHORT_GO 1
`define URX_IRQ_RD_REWIND 2
`define URX_IRQ_WR_REWIND 3

// ----------------------------------------
// Timing
// ----------------------------------------
`define URX_DLY_UNIT_PS 32'd16667
`define URX_CLK_PERIOD_PS 32'd20000

`endif

// ---- hw/urx_pkg.sv ----
// Types for the receive-path status register bank
`default_nettype none

package urx_pkg;
    typedef enum logic [2:0]
    {
        URX_DLY_IDLE = 3'b001,
        URX_DLY_WAIT = 3'b010,
        URX_DLY_FIRE = 3'b100
    } urx_dly_state_e;
    typedef logic [13:0] urx_level_t;
    typedef logic [12:0] urx_ptr_t;
endpackage

`default_nettype wire

// ---- hw/urx_regs.sv ----
// Receive-path control, status-packet gating, short-packet delay and FIFO debug
//
// Added by the designer: the strobed register port.
`default_nettype none
`include "urx_defines.svh"

module urx_regs
(
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_irq,
    input wire logic [8:0] i_mac_events,
    input wire logic [10:0] i_gpio_events,
    input wire logic i_ep_interval_tick,
    output logic o_status_send,
    output logic [19:0] o_status_word,
    input wire logic i_short_pkt_pending,
    output logic o_short_pkt_go,
    input wire logic i_rxw_dword,
    input wire logic i_rxw_eop,
    input wire logic i_rxw_fcs_err,
    input wire logic i_rxr_dword,
    input wire logic i_rxr_done,
    input wire logic i_rxr_usb_err,
    output logic o_rxr_retransmit,
    output logic [12:0] o_rx_rd_ptr,
    output logic [12:0] o_rx_wr_ptr
);

    // ----------------------------------------
    // Register bus decode
    // ----------------------------------------
    wire logic sel_ctl;
    wire logic sel_dly;
    wire logic sel_lvl;
    wire logic sel_ptr;
    wire logic sel_stat;
    wire logic sel_mask;
    assign sel_ctl = (i_addr == `URX_OFS_EP_CONTROL);
    assign sel_dly = (i_addr == `URX_OFS_BULK_DLY);
    assign sel_lvl = (i_addr == `URX_OFS_LVL_DBG);
    assign sel_ptr = (i_addr == `URX_OFS_PTR_DBG);
    assign sel_stat = (i_addr == `URX_OFS_IRQ_STAT);
    assign sel_mask = (i_addr == `URX_OFS_IRQ_MASK);

    logic [31:0] interrupt_endpoint_control;
    logic [15:0] bulk_in_short_packet_delay;
    logic [`URX_IRQ_BITS-1:0] irq_status;
    logic [`URX_IRQ_BITS-1:0] irq_mask;

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            interrupt_endpoint_control <= `URX_CTL_RESET;  // [RULE_15]
            bulk_in_short_packet_delay <= `URX_DLY_RESET;  // [RULE_04]
            irq_mask <= '0;
        end
        else if (i_wr)
        begin
            if (sel_ctl)
                interrupt_endpoint_control <= i_wdata & `URX_CTL_WR_MASK;  // [RULE_15]
            if (sel_dly)
                bulk_in_short_packet_delay <= i_wdata[15:0];
            if (sel_mask)
                irq_mask <= i_wdata[`URX_IRQ_BITS-1:0];
        end
    end

    wire logic status_packet_always_on;
    wire logic [8:0] mac_event_enables;
    wire logic [10:0] general_pin_event_enables;
    assign status_packet_always_on = interrupt_endpoint_control[`URX_CTL_ALWAYS_ON];
    assign mac_event_enables = interrupt_endpoint_control[19:11];
    assign general_pin_event_enables = interrupt_endpoint_control[10:0];

    // ----------------------------------------
    // Status packet gating
    // ----------------------------------------
    wire logic [19:0] event_hits;
    wire logic [19:0] pending_all;
    wire logic next_status_send;
    logic [19:0] pending;

    assign event_hits[19:11] = i_mac_events & mac_event_enables;  // [RULE_02]
    assign event_hits[10:0] = i_gpio_events & general_pin_event_enables;  // [RULE_03]
    assign pending_all = pending | event_hits;
    assign next_status_send = i_ep_interval_tick
        & (status_packet_always_on | (|pending_all));  // [RULE_01]

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            pending <= '0;
            o_status_send <= 1'b0;
            o_status_word <= '0;
        end
        else
        begin
            // Events in the tick cycle are reported now, not lost
            pending <= i_ep_interval_tick ? 20'h0_0000 : pending_all;
            o_status_send <= next_status_send;
            if (next_status_send)
                o_status_word <= pending_all;
        end
    end

    // ----------------------------------------
    // Short bulk-in packet delay
    // ----------------------------------------
    urx_pkg::urx_dly_state_e dly_state;
    urx_pkg::urx_dly_state_e next_dly_state;
    logic [31:0] dly_target_ps;
    logic [31:0] dly_elapsed_ps;
    wire logic [31:0] next_elapsed_ps;
    wire logic dly_done;

    assign next_elapsed_ps = dly_elapsed_ps + `URX_CLK_PERIOD_PS;
    assign dly_done = (next_elapsed_ps >= dly_target_ps);  // [RULE_04]

    always_comb
    begin
        next_dly_state = dly_state;
        unique case (dly_state)
            urx_pkg::URX_DLY_IDLE:
            begin
                if (i_short_pkt_pending)
                    next_dly_state = urx_pkg::URX_DLY_WAIT;
            end
            urx_pkg::URX_DLY_WAIT:
            begin
                if (!i_short_pkt_pending)
                    next_dly_state = urx_pkg::URX_DLY_IDLE;
                else if (dly_done)
                    next_dly_state = urx_pkg::URX_DLY_FIRE;
            end
            urx_pkg::URX_DLY_FIRE:
            begin
                next_dly_state = urx_pkg::URX_DLY_IDLE;
            end
            default:
            begin
                next_dly_state = urx_pkg::URX_DLY_IDLE;
            end
        endcase
    end

    wire logic dly_load;
    wire logic next_short_go;
    assign dly_load = (dly_state == urx_pkg::URX_DLY_IDLE) & i_short_pkt_pending;
    assign next_short_go = (next_dly_state == urx_pkg::URX_DLY_FIRE);

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            dly_state <= urx_pkg::URX_DLY_IDLE;
            dly_target_ps <= '0;
            dly_elapsed_ps <= '0;
            o_short_pkt_go <= 1'b0;
        end
        else
        begin
            dly_state <= next_dly_state;
            o_short_pkt_go <= next_short_go;
            if (dly_load)
            begin
                // Delay in picoseconds, counts of 16.667 ns
                dly_target_ps <= 32'(bulk_in_short_packet_delay) * `URX_DLY_UNIT_PS;  // [RULE_04]
                dly_elapsed_ps <= '0;
            end
            else if (dly_state == urx_pkg::URX_DLY_WAIT)
                dly_elapsed_ps <= next_elapsed_ps;
        end
    end

    // ----------------------------------------
    // Receive FIFO write side
    // ----------------------------------------
    urx_pkg::urx_ptr_t receive_write_pointer;
    urx_pkg::urx_ptr_t wr_pkt_start;
    urx_pkg::urx_level_t wr_pkt_len;
    urx_pkg::urx_level_t receive_write_level;
    wire urx_pkg::urx_ptr_t wr_ptr_inc;
    wire urx_pkg::urx_ptr_t next_wr_ptr;
    wire urx_pkg::urx_level_t wr_len_now;

    assign wr_ptr_inc = (receive_write_pointer == `URX_PTR_LAST) ? 13'h0000
        : receive_write_pointer + 13'h0001;  // [RULE_16]
    assign next_wr_ptr = i_rxw_fcs_err ? wr_pkt_start  // [RULE_12]
        : (i_rxw_dword ? wr_ptr_inc : receive_write_pointer);
    assign wr_len_now = wr_pkt_len + {13'h0000, i_rxw_dword};

    // ----------------------------------------
    // Receive FIFO read side
    // ----------------------------------------
    urx_pkg::urx_ptr_t receive_read_pointer;
    urx_pkg::urx_ptr_t rd_pkt_start;
    urx_pkg::urx_level_t rd_pkt_len;
    urx_pkg::urx_level_t receive_read_level;
    wire urx_pkg::urx_ptr_t rd_ptr_inc;
    wire urx_pkg::urx_ptr_t next_rd_ptr;
    wire urx_pkg::urx_level_t rd_len_now;

    assign rd_ptr_inc = (receive_read_pointer == `URX_PTR_LAST) ? 13'h0000
        : receive_read_pointer + 13'h0001;  // [RULE_16]
    assign next_rd_ptr = i_rxr_usb_err ? rd_pkt_start  // [RULE_08]
        : (i_rxr_dword ? rd_ptr_inc : receive_read_pointer);
    assign rd_len_now = rd_pkt_len + {13'h0000, i_rxr_dword};

    // ----------------------------------------
    // Level arithmetic
    // ----------------------------------------
    wire urx_pkg::urx_level_t wr_lvl_add;
    wire urx_pkg::urx_level_t wr_lvl_sub;
    wire urx_pkg::urx_level_t rd_lvl_add;
    wire urx_pkg::urx_level_t rd_lvl_sub;
    wire urx_pkg::urx_level_t next_wr_level;
    wire urx_pkg::urx_level_t next_rd_level;

    assign wr_lvl_add = {13'h0000, i_rxw_dword & ~i_rxw_fcs_err};  // [RULE_09]
    assign wr_lvl_sub = (i_rxw_fcs_err ? wr_pkt_len : 14'h0000)  // [RULE_11]
        + ((i_rxr_done & ~i_rxr_usb_err) ? rd_len_now : 14'h0000);  // [RULE_10]
    assign rd_lvl_add = ((i_rxw_eop & ~i_rxw_fcs_err) ? wr_len_now : 14'h0000)  // [RULE_05]
        + (i_rxr_usb_err ? rd_pkt_len : 14'h0000);  // [RULE_07]
    assign rd_lvl_sub = {13'h0000, i_rxr_dword & ~i_rxr_usb_err};  // [RULE_06]
    assign next_wr_level = receive_write_level + wr_lvl_add - wr_lvl_sub;
    assign next_rd_level = receive_read_level + rd_lvl_add - rd_lvl_sub;

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            receive_write_pointer <= '0;  // [RULE_14]
            wr_pkt_start <= '0;
            wr_pkt_len <= '0;
        end
        else
        begin
            receive_write_pointer <= next_wr_ptr;
            if (i_rxw_fcs_err | i_rxw_eop)
                wr_pkt_len <= '0;
            else
                wr_pkt_len <= wr_len_now;
            if (i_rxw_eop & ~i_rxw_fcs_err)
                wr_pkt_start <= next_wr_ptr;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            receive_read_pointer <= '0;  // [RULE_13]
            rd_pkt_start <= '0;
            rd_pkt_len <= '0;
            o_rxr_retransmit <= 1'b0;
        end
        else
        begin
            receive_read_pointer <= next_rd_ptr;
            o_rxr_retransmit <= i_rxr_usb_err;  // [RULE_08]
            if (i_rxr_usb_err | i_rxr_done)
                rd_pkt_len <= '0;
            else
                rd_pkt_len <= rd_len_now;
            if (i_rxr_done & ~i_rxr_usb_err)
                rd_pkt_start <= next_rd_ptr;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            receive_write_level <= '0;
            receive_read_level <= '0;
        end
        else
        begin
            receive_write_level <= next_wr_level;
            receive_read_level <= next_rd_level;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_rx_rd_ptr <= '0;
            o_rx_wr_ptr <= '0;
        end
        else
        begin
            o_rx_rd_ptr <= next_rd_ptr;
            o_rx_wr_ptr <= next_wr_ptr;
        end
    end

    // ----------------------------------------
    // Interrupt status, cleared by read
    // ----------------------------------------
    wire logic [`URX_IRQ_BITS-1:0] irq_events;
    wire logic [`URX_IRQ_BITS-1:0] next_irq_status;
    wire logic stat_read;

    assign irq_events[`URX_IRQ_STATUS_SENT] = next_status_send;
    assign irq_events[`URX_IRQ_SHORT_GO] = next_short_go;
    assign irq_events[`URX_IRQ_RD_REWIND] = i_rxr_usb_err;
    assign irq_events[`URX_IRQ_WR_REWIND] = i_rxw_fcs_err;
    assign stat_read = i_rd & sel_stat;
    // Set wins over the read clear
    assign next_irq_status = (stat_read ? '0 : irq_status) | irq_events;

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            irq_status <= '0;
            o_irq <= 1'b0;
        end
        else
        begin
            irq_status <= next_irq_status;
            o_irq <= |(next_irq_status & irq_mask);
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    wire logic [31:0] lvl_word;
    wire logic [31:0] ptr_word;
    wire logic [31:0] next_rdata;

    assign lvl_word = {2'b00, receive_read_level, 2'b00, receive_write_level};
    assign ptr_word = {3'b000, receive_read_pointer, 3'b000, receive_write_pointer};
    assign next_rdata =
        sel_ctl ? interrupt_endpoint_control :
        sel_dly ? {16'h0000, bulk_in_short_packet_delay} :
        sel_lvl ? lvl_word :
        sel_ptr ? ptr_word :  // [RULE_13] [RULE_14]
        sel_stat ? {28'h000_0000, irq_status} :
        sel_mask ? {28'h000_0000, irq_mask} :
        32'h0000_0000;

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_rdata <= '0;
        else if (i_rd)
            o_rdata <= next_rdata;
        else
            o_rdata <= '0;
    end

endmodule // urx_regs

`default_nettype wire

// ---- sim/urx_regs_assertions.sv ----
// Concurrent checks on the receive-path register bank ports
`default_nettype none
module urx_regs_assertions
(
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic i_ep_interval_tick,
    input wire logic o_status_send,
    input wire logic [19:0] o_status_word,
    input wire logic i_short_pkt_pending,
    input wire logic o_short_pkt_go,
    input wire logic i_rxw_dword,
    input wire logic i_rxw_fcs_err,
    input wire logic i_rxr_dword,
    input wire logic i_rxr_usb_err,
    input wire logic o_rxr_retransmit,
    input wire logic [12:0] o_rx_rd_ptr,
    input wire logic [12:0] o_rx_wr_ptr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_b);
    // Shadow of the endpoint control register
    logic [31:0] ctl;
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            ctl <= 32'h0;
        else if (i_wr && i_addr == 8'h68)
            ctl <= i_wdata;
    end
    a_always_sends: assert property (i_ep_interval_tick && ctl[31] |=> o_status_send)
        else $error("no status packet in always-on mode");
    a_send_on_tick: assert property (o_status_send |-> $past(i_ep_interval_tick))
        else $error("status packet without interval tick");
    a_word_enabled: assert property (o_status_send
        |-> (o_status_word & ~ctl[19:0]) == 20'h0)
        else $error("disabled event reported");
    a_resv_zero: assert property (i_rd && i_addr == 8'h68 |=> o_rdata[30:20] == 11'h0)
        else $error("reserved control bits not zero");
    a_go_pulse: assert property (o_short_pkt_go |=> !o_short_pkt_go)
        else $error("short packet go longer than one cycle");
    a_go_not_early: assert property ($rose(i_short_pkt_pending) |=> !o_short_pkt_go)
        else $error("short packet sent without delay");
    a_retx_follows: assert property (i_rxr_usb_err |=> o_rxr_retransmit)
        else $error("no retransmit after usb error");
    a_wptr_step: assert property (i_rxw_dword && !i_rxw_fcs_err
        |=> o_rx_wr_ptr == $past(o_rx_wr_ptr) + 13'h1)
        else $error("write pointer step wrong");
    a_rptr_step: assert property (i_rxr_dword && !i_rxr_usb_err
        |=> o_rx_rd_ptr == $past(o_rx_rd_ptr) + 13'h1)
        else $error("read pointer step wrong");
    a_rptr_hold: assert property (!i_rxr_dword && !i_rxr_usb_err
        |=> $stable(o_rx_rd_ptr))
        else $error("read pointer moved without cause");
    c_status: cover property (o_status_send && o_status_word != 20'h0);
    c_go: cover property (o_short_pkt_go);
    c_retx: cover property (o_rxr_retransmit);
endmodule // urx_regs_assertions

bind urx_regs urx_regs_assertions u_check (.i_core_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .i_ep_interval_tick, .o_status_send, .o_status_word, .i_short_pkt_pending,
    .o_short_pkt_go, .i_rxw_dword, .i_rxw_fcs_err, .i_rxr_dword, .i_rxr_usb_err,
    .o_rxr_retransmit, .o_rx_rd_ptr, .o_rx_wr_ptr);
`default_nettype wire

// ---- sim/urx_host_model.sv ----
// Behavioural USB host polling the interrupt and bulk-in endpoints
`default_nettype none
module urx_host_model
(
    input wire logic i_core_clk,
    input wire logic i_go,
    input wire logic [31:0] i_len,
    input wire logic [31:0] i_err_at,
    input wire logic i_retransmit,
    output logic o_tick,
    output logic o_rd_dword,
    output logic o_rd_done,
    output logic o_usb_err,
    output logic o_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    // Interrupt endpoint poll every 16 cycles
    initial
    begin
        o_tick = 1'b0;
        forever
        begin
            repeat (15) @(posedge i_core_clk);
            o_tick <= 1'b1;
            @(posedge i_core_clk);
            o_tick <= 1'b0;
        end
    end
    // Reads n dwords, stalling after every third
    task automatic fetch(int n, logic full);
        for (int k = 1; k <= n; k++)
        begin
            o_rd_dword <= 1'b1;
            o_rd_done <= full && k == n;
            @(posedge i_core_clk);
            if (k % 3 == 0 && k < n)
            begin
                o_rd_dword <= 1'b0;
                @(posedge i_core_clk);
            end
        end
        o_rd_dword <= 1'b0;
        o_rd_done <= 1'b0;
    endtask
    initial
    begin
        o_rd_dword = 1'b0;
        o_rd_done = 1'b0;
        o_usb_err = 1'b0;
        o_busy = 1'b0;
        forever
        begin
            @(posedge i_core_clk);
            if (i_go)
            begin
                o_busy <= 1'b1;
                if (i_err_at != 0)
                begin
                    fetch(i_err_at, 1'b0);
                    o_usb_err <= 1'b1;
                    @(posedge i_core_clk);
                    o_usb_err <= 1'b0;
                    @(posedge i_core_clk);
                    // Whole packet again only when the device asks
                    if (i_retransmit === 1'b1)
                        fetch(i_len, 1'b1);
                end
                else
                    fetch(i_len, 1'b1);
                o_busy <= 1'b0;
            end
        end
    end
endmodule // urx_host_model
`default_nettype wire

// ---- sim/test_usb_rx_path_status_regs.sv ----
// Self-checking bench for the receive-path register bank
`default_nettype none
module test_usb_rx_path_status_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_core_clk, i_rst_b, i_wr, i_rd, o_irq, i_ep_interval_tick, o_status_send;
    logic i_short_pkt_pending, o_short_pkt_go, i_rxw_dword, i_rxw_eop, i_rxw_fcs_err;
    logic i_rxr_dword, i_rxr_done, i_rxr_usb_err, o_rxr_retransmit, h_go, h_busy;
    logic [7:0] i_addr;
    logic [31:0] i_wdata, o_rdata, h_len, h_err;
    logic [8:0] i_mac_events;
    logic [10:0] i_gpio_events;
    logic [19:0] o_status_word, m;
    logic [12:0] o_rx_rd_ptr, o_rx_wr_ptr;
    int error_cnt, check_count, wl, rl, wp, rp, plen, n;
    int dly[4] = '{0, 1, 3, 60};
    urx_regs dut (.i_core_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq,
        .i_mac_events, .i_gpio_events, .i_ep_interval_tick, .o_status_send, .o_status_word,
        .i_short_pkt_pending, .o_short_pkt_go, .i_rxw_dword, .i_rxw_eop, .i_rxw_fcs_err,
        .i_rxr_dword, .i_rxr_done, .i_rxr_usb_err, .o_rxr_retransmit, .o_rx_rd_ptr,
        .o_rx_wr_ptr);
    urx_host_model host (.i_core_clk, .i_go(h_go), .i_len(h_len), .i_err_at(h_err),
        .i_retransmit(o_rxr_retransmit), .o_tick(i_ep_interval_tick), .o_rd_dword(i_rxr_dword),
        .o_rd_done(i_rxr_done), .o_usb_err(i_rxr_usb_err), .o_busy(h_busy));
    initial
    begin
        i_core_clk = 1'b0;
        forever #10 i_core_clk = ~i_core_clk;
    end
    task automatic wrap_up();
        if (error_cnt == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic tmo();
        error_cnt++;
        $display("[FAIL] wait expected done seen timeout");
        wrap_up();
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr_reg(logic [7:0] a, logic [31:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        @(posedge i_core_clk);
    endtask
    task automatic rd_chk(logic [7:0] a, logic [31:0] e);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), e, o_rdata);
        @(posedge i_core_clk);
    endtask
    task automatic lvl();
        rd_chk(8'h70, {2'h0, rl[13:0], 2'h0, wl[13:0]});
        rd_chk(8'h74, {3'h0, rp[12:0], 3'h0, wp[12:0]});
        #1;
        chk("ptrs", {3'h0, rp[12:0], 3'h0, wp[12:0]}, {3'h0, o_rx_rd_ptr, 3'h0, o_rx_wr_ptr});
        @(posedge i_core_clk);
    endtask
    task automatic fire(logic [19:0] ev);
        {i_mac_events, i_gpio_events} <= ev;
        @(posedge i_core_clk);
        {i_mac_events, i_gpio_events} <= 20'h0;
        @(posedge i_core_clk);
    endtask
    task automatic wait_send(logic e);
        n = 0;
        do
        begin
            @(posedge i_core_clk);
            #1;
            n++;
        end while (o_status_send !== 1'b1 && n < 40);
        if (e && n == 40)
            tmo();
        chk("status_send", e, o_status_send);
        @(posedge i_core_clk);
    endtask
    task automatic short_go(int d);
        int e;
        e = (d * 16667 + 19999) / 20000 + 1;
        if (e < 2)
            e = 2;
        n = 0;
        i_short_pkt_pending <= 1'b1;
        do
        begin
            @(posedge i_core_clk);
            #1;
            n++;
        end while (o_short_pkt_go !== 1'b1 && n < 3000);
        if (n == 3000)
            tmo();
        chk("short_go_cycle", e, n);
        @(posedge i_core_clk);
        i_short_pkt_pending <= 1'b0;
    endtask
    task automatic push(int len, logic last);
        for (int k = 1; k <= len; k++)
        begin
            i_rxw_dword <= 1'b1;
            i_rxw_eop <= last && k == len;
            @(posedge i_core_clk);
        end
        i_rxw_dword <= 1'b0;
        i_rxw_eop <= 1'b0;
        wl += len;
        wp += len;
        plen += len;
        if (last)
        begin
            rl += plen;
            plen = 0;
        end
        @(posedge i_core_clk);
    endtask
    task automatic fcs();
        i_rxw_fcs_err <= 1'b1;
        @(posedge i_core_clk);
        i_rxw_fcs_err <= 1'b0;
        wl -= plen;
        wp -= plen;
        plen = 0;
        @(posedge i_core_clk);
    endtask
    task automatic pull(int len, int err);
        h_len <= len;
        h_err <= err;
        h_go <= 1'b1;
        @(posedge i_core_clk);
        h_go <= 1'b0;
        n = 0;
        do
        begin
            @(posedge i_core_clk);
            #1;
            n++;
        end while (h_busy !== 1'b0 && n < 20000);
        if (n == 20000)
            tmo();
        rl -= len;
        wl -= len;
        rp += len;
        @(posedge i_core_clk);
    endtask
    initial
    begin
        #2000000;
        tmo();
    end
    initial
    begin
        i_rst_b = 1'b0;
        {i_wr, i_rd, i_short_pkt_pending, i_rxw_dword, i_rxw_eop, i_rxw_fcs_err, h_go} = '0;
        {i_addr, i_wdata, i_mac_events, i_gpio_events, h_len, h_err} = '0;
        repeat (2) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        @(posedge i_core_clk);
        n = $urandom(72648);
        rd_chk(8'h68, 32'h0);
        rd_chk(8'h6C, 32'h800);
        lvl();
        rd_chk(8'h40, 32'h0);
        wr_reg(8'h68, 32'hFFFF_FFFF);
        rd_chk(8'h68, 32'h800F_FFFF);
        wr_reg(8'h74, 32'hFFFF_FFFF);
        lvl();
        short_go(2048);
        foreach (dly[i])
        begin
            wr_reg(8'h6C, dly[i]);
            short_go(dly[i]);
        end
        for (int i = 0; i < 20; i++)
        begin
            m = 20'h1 << i;
            wr_reg(8'h68, {12'h0, m});
            fire(m | (20'($urandom) & ~m));
            wait_send(1'b1);
            chk("status_word", {12'h0, m}, {12'h0, o_status_word});
        end
        wr_reg(8'h68, 32'h0);
        fire(20'hF_FFFF);
        wait_send(1'b0);
        wr_reg(8'h68, 32'h8000_0000);
        wait_send(1'b1);
        wait_send(1'b1);
        chk("status_word", 32'h0, {12'h0, o_status_word});
        push(3, 1'b1);
        lvl();
        push(2, 1'b0);
        lvl();
        fcs();
        lvl();
        pull(3, 2);
        lvl();
        push(8200, 1'b1);
        pull(8200, 0);
        lvl();
        wr_reg(8'h68, 32'h0);
        wr_reg(8'h84, 32'h0);
        #1;
        chk("irq", 32'h0, {31'h0, o_irq});
        @(posedge i_core_clk);
        wr_reg(8'h84, 32'hF);
        #1;
        chk("irq", 32'h1, {31'h0, o_irq});
        @(posedge i_core_clk);
        rd_chk(8'h80, 32'hF);
        #1;
        chk("irq", 32'h0, {31'h0, o_irq});
        wrap_up();
    end
endmodule // test_usb_rx_path_status_regs
`default_nettype wire
